// ===== logic/otdb_pkg.sv
// constants and state type for the ook threshold demodulator and bit recovery unit
package otdb_pkg;

  // rssi lsb is 0.5 dB
  localparam logic [8:0] PEAK_OFFSET   = 9'h00c;
  localparam logic [3:0] SUB_LAST      = 4'hf;
  localparam logic [3:0] CENTER_SUB    = 4'h8;
  localparam logic [1:0] SUB_TICK_FRAC = 2'h3;
  localparam logic [4:0] LOCK_BITS     = 5'h18;
  localparam logic [2:0] BYTE_LAST     = 3'h7;

  typedef enum logic [1:0] {
    OTDB_THR_PEAK  = 2'b00,
    OTDB_THR_FIXED = 2'b01,
    OTDB_THR_AVG   = 2'b10
  } otdb_thr_t;

  typedef enum logic [1:0] {
    OTDB_MODE_CONT   = 2'b00,
    OTDB_MODE_BUFFER = 2'b01,
    OTDB_MODE_PACKET = 2'b10
  } otdb_mode_t;

  // decrement step in 0.5 dB units
  function automatic logic [8:0] otdb_step(input logic [2:0] code);
    case (code)
      3'h0: otdb_step = 9'h001;
      3'h1: otdb_step = 9'h002;
      3'h2: otdb_step = 9'h003;
      3'h3: otdb_step = 9'h004;
      3'h4: otdb_step = 9'h006;
      3'h5: otdb_step = 9'h008;
      3'h6: otdb_step = 9'h00a;
      default: otdb_step = 9'h00c;
    endcase
  endfunction

  // decrement interval in sixteenths of a chip, minus one
  function automatic logic [6:0] otdb_period(input logic [2:0] code);
    case (code)
      3'h0: otdb_period = 7'h0f;
      3'h1: otdb_period = 7'h1f;
      3'h2: otdb_period = 7'h3f;
      3'h3: otdb_period = 7'h7f;
      3'h4: otdb_period = 7'h07;
      3'h5: otdb_period = 7'h03;
      3'h6: otdb_period = 7'h01;
      default: otdb_period = 7'h00;
    endcase
  endfunction

  // average filter shift: bit rate over 8 pi .. over 32 pi
  function automatic logic [2:0] otdb_shift(input logic [1:0] code);
    case (code)
      2'h0: otdb_shift = 3'h2;
      2'h1: otdb_shift = 3'h3;
      2'h2: otdb_shift = 3'h3;
      default: otdb_shift = 3'h4;
    endcase
  endfunction

  typedef struct packed {
    logic [15:0][7:0] win;
    logic [3:0]       wptr;
    logic [11:0]      sum;
    logic [7:0]       rssi;
    logic [7:0]       peak;
    logic [11:0]      acc;
    logic             ook_q;
    logic [8:0]       tick_cnt;
    logic [3:0]       sub;
    logic [6:0]       dec_cnt;
    logic             raw_q;
    logic             edge_seen;
    logic [4:0]       lock_cnt;
    logic             bit_val;
    logic             recovered_bit_clock;
    logic             ib1;
    logic             ib2;
    logic             ib3;
    logic             ib_lvl;
    logic             synced_seen;
    logic [7:0]       sh;
    logic [2:0]       bitcnt;
    logic             wr_valid;
    logic [7:0]       wr_data;
    logic             data_out;
    logic             line_a;
    logic             line_b;
    logic             line_b_oe;
    logic             fifo_flag;
  } otdb_state_t;

endpackage

// ===== logic/otdb_core.sv
// ook threshold demodulator, bit recovery unit and receive data path
// Functional notes
// - fsk data via sync or raw continuous
// - ook compares rssi to selected threshold type
// - peak threshold is tracked peak minus 6 dB
// - peak decays per period on zero/no signal
// - peak threshold stops and holds at floor
// - decrement period code decode table
// - decrement step code decode, default 0.5 dB
// - fixed mode compares against programmed constant
// - average mode low-pass filters rssi
// - bypass needs bypass bit and line low
// - sync always on in buffered/packet modes
// - bit rate is clock over 64(1+value)
// - clock rising edge centred, realigned on transitions
// - equal rates tolerate unlimited equal runs
// - continuous on data pin, else fifo
// - bits shifted in, bytes moved out
// - fifo writes only after sync match
// - fifo flag on selected interrupt line
// - rssi is 16-sample sliding average
`timescale 1ns/1ps
module otdb_core
  import otdb_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // demodulator inputs
  input  wire logic [7:0] rssi_sample,
  input  wire logic       rssi_sample_valid,
  input  wire logic       fsk_raw_data,
  input  wire logic       ook_select,
  // configuration
  input  wire logic [1:0] data_mode,
  input  wire logic [1:0] ook_threshold_type,
  input  wire logic [2:0] peak_decrement_step,
  input  wire logic [2:0] peak_decrement_period,
  input  wire logic [7:0] floor_threshold_value,
  input  wire logic [7:0] fixed_threshold_value,
  input  wire logic [1:0] average_cutoff_select,
  input  wire logic [6:0] bit_rate_value,
  input  wire logic       bit_sync_bypass,
  // receive control
  input  wire logic       rx_enable,
  input  wire logic       sync_match,
  input  wire logic       fifo_enable,
  input  wire logic       fifo_irq_on_b,
  input  wire logic [6:0] fifo_fill_count,
  input  wire logic [6:0] fifo_fill_limit,
  // fifo write side
  output logic            fifo_wr_valid,
  output logic [7:0]      fifo_wr_data,
  // pins
  output logic            data_pin,
  output logic            interrupt_line_a,
  input  wire logic       interrupt_line_b_in,
  output logic            interrupt_line_b_out,
  output logic            interrupt_line_b_oe,
  // status
  output logic [7:0]      rssi_value,
  output logic [7:0]      tracked_peak,
  output logic            bit_sync_locked,
  output logic            fifo_level_flag
);

  otdb_state_t s;
  otdb_state_t n;
  logic        cont;
  logic        bypass_eff;
  logic        sub_tick;
  logic        bit_strobe;
  logic        dec_tick;
  logic        demod;
  logic        edge_det;
  logic        locked;
  logic [8:0]  floor_peak;
  logic [8:0]  peak_low;
  logic [7:0]  thr;
  logic [8:0]  dec_val;
  logic [11:0] rssi16;
  logic [2:0]  shamt;

  assign cont       = (data_mode == OTDB_MODE_CONT);
  assign locked     = (s.lock_cnt == LOCK_BITS);
  assign bypass_eff = cont & bit_sync_bypass & ~s.ib_lvl;
  assign demod      = ook_select ? s.ook_q : fsk_raw_data;
  assign edge_det   = demod != s.raw_q;
  // sixteen sub ticks of 4(1+value) cycles make one bit
  assign sub_tick   = s.tick_cnt == {bit_rate_value, SUB_TICK_FRAC};
  assign bit_strobe = sub_tick & ~edge_det & (s.sub == CENTER_SUB - 4'h1);
  assign dec_tick   = sub_tick & (s.dec_cnt == otdb_period(peak_decrement_period));
  assign floor_peak = {1'b0, floor_threshold_value} + PEAK_OFFSET;
  assign peak_low   = {1'b0, s.peak} - PEAK_OFFSET;
  assign dec_val    = {1'b0, s.peak} - otdb_step(peak_decrement_step);
  assign rssi16     = {s.rssi, 4'h0};
  assign shamt      = otdb_shift(average_cutoff_select);

  // threshold select
  always_comb begin
    case (ook_threshold_type)
      OTDB_THR_PEAK: begin
        // peak minus offset, never below the floor
        if ({1'b0, s.peak} < floor_peak) begin
          thr = floor_threshold_value;
        end else begin
          thr = peak_low[7:0];
        end
      end
      OTDB_THR_FIXED: thr = fixed_threshold_value;
      default:        thr = s.acc[11:4];
    endcase
  end

  always_comb begin
    n = s;
    n.wr_valid = 1'b0;
    // pin synchroniser, level taken when stages two and three agree
    n.ib1 = interrupt_line_b_in;
    n.ib2 = s.ib1;
    n.ib3 = s.ib2;
    if (s.ib2 == s.ib3) begin
      n.ib_lvl = s.ib3;
    end
    // sliding average over sixteen samples
    if (rssi_sample_valid) begin
      n.sum = s.sum - {4'h0, s.win[s.wptr]} + {4'h0, rssi_sample};
      n.win[s.wptr] = rssi_sample;
      n.wptr = s.wptr + 4'h1;
      n.rssi = n.sum[11:4];
    end
    n.ook_q = s.rssi > thr;
    // peak tracking; a rise always beats a decay
    if (s.rssi > s.peak) begin
      n.peak = s.rssi;
    end else if (dec_tick & ~s.ook_q) begin
      if (dec_val < floor_peak) begin
        n.peak = (floor_peak[8]) ? 8'hff : floor_peak[7:0];
      end else begin
        n.peak = dec_val[7:0];
      end
    end
    if (sub_tick) begin
      n.dec_cnt = dec_tick ? 7'h00 : s.dec_cnt + 7'h01;
    end
    // single pole filter updated once per bit
    if (sub_tick & (s.sub == SUB_LAST)) begin
      if (rssi16 >= s.acc) begin
        n.acc = s.acc + ((rssi16 - s.acc) >> shamt);
      end else begin
        n.acc = s.acc - ((s.acc - rssi16) >> shamt);
      end
    end
    // bit recovery: transitions restart the bit, centre is sampled
    n.raw_q = demod;
    n.tick_cnt = sub_tick ? 9'h000 : s.tick_cnt + 9'h001;
    if (edge_det) begin
      n.sub = 4'h0;
      n.tick_cnt = 9'h000;
      n.edge_seen = 1'b1;
    end else if (sub_tick) begin
      n.sub = s.sub + 4'h1;
    end
    if (bit_strobe) begin
      n.bit_val = demod;
      n.edge_seen = 1'b0;
      if (s.edge_seen & ~locked) begin
        n.lock_cnt = s.lock_cnt + 5'h01;
      end else if (~locked) begin
        n.lock_cnt = 5'h00;
      end
    end
    n.recovered_bit_clock = n.sub >= CENTER_SUB;
    // byte assembly after a sync match
    if (~rx_enable | cont) begin
      n.synced_seen = 1'b0;
      n.bitcnt = 3'h0;
    end else begin
      if (sync_match) begin
        n.synced_seen = 1'b1;
      end
      if (bit_strobe & s.synced_seen & locked) begin
        n.sh = {s.sh[6:0], demod};
        n.bitcnt = s.bitcnt + 3'h1;
        if (s.bitcnt == BYTE_LAST) begin
          n.wr_valid = 1'b1;
          n.wr_data = {s.sh[6:0], demod};
        end
      end
    end
    // data pin and interrupt lines
    if (~cont) begin
      n.data_out = 1'b0;
    end else if (bypass_eff) begin
      n.data_out = demod;
    end else begin
      n.data_out = s.bit_val;
    end
    n.fifo_flag = fifo_enable & ~cont & (fifo_fill_count >= fifo_fill_limit);
    n.line_a = n.fifo_flag & ~fifo_irq_on_b;
    // released in continuous mode while bypass bit set so the host can hold it low
    n.line_b_oe = cont ? ~bit_sync_bypass : fifo_irq_on_b;
    n.line_b = cont ? n.recovered_bit_clock : n.fifo_flag;
  end

  // reset clears all state, so peak, rssi, filter and counters start at zero
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign fifo_wr_valid        = s.wr_valid;
  assign fifo_wr_data         = s.wr_data;
  assign data_pin             = s.data_out;
  assign interrupt_line_a     = s.line_a;
  assign interrupt_line_b_out = s.line_b;
  assign interrupt_line_b_oe  = s.line_b_oe;
  assign rssi_value           = s.rssi;
  assign tracked_peak         = s.peak;
  assign bit_sync_locked      = locked;
  assign fifo_level_flag      = s.fifo_flag;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_edge_restart;
    edge_det ##1 (s.sub == 4'h0);
  endsequence

  sequence s_clock_low;
    !s.recovered_bit_clock;
  endsequence

  property p_peak_rise;
    (s.rssi > s.peak) |=> (s.peak == $past(s.rssi));
  endproperty
  a_peak_rise: assert property (p_peak_rise) else $error("peak did not follow rssi");

  property p_floor;
    (ook_threshold_type == OTDB_THR_PEAK) |-> (thr >= floor_threshold_value);
  endproperty
  a_floor: assert property (p_floor) else $error("peak threshold below floor");

  property p_decay;
    (s.rssi <= s.peak) && !dec_tick |=> (s.peak == $past(s.peak));
  endproperty
  a_decay: assert property (p_decay) else $error("peak moved off a decrement tick");

  property p_fixed;
    (ook_threshold_type == OTDB_THR_FIXED) |=>
      (s.ook_q == ($past(s.rssi) > $past(fixed_threshold_value)));
  endproperty
  a_fixed: assert property (p_fixed) else $error("fixed compare wrong");

  property p_data_off;
    !cont |=> !data_pin;
  endproperty
  a_data_off: assert property (p_data_off) else $error("data pin active outside continuous");

  property p_sync_on;
    !cont |-> !bypass_eff;
  endproperty
  a_sync_on: assert property (p_sync_on) else $error("bit sync bypassed in fifo mode");

  property p_wr_after_sync;
    fifo_wr_valid |-> $past(s.synced_seen, 2);
  endproperty
  a_wr_after_sync: assert property (p_wr_after_sync) else $error("fifo write before sync");

  property p_centre;
    edge_det |-> s_edge_restart ##0 s_clock_low;
  endproperty
  a_centre: assert property (p_centre) else $error("clock not realigned on transition");

  property p_rising_at_centre;
    bit_strobe |=> s.recovered_bit_clock && (s.sub == CENTER_SUB);
  endproperty
  a_rising_at_centre: assert property (p_rising_at_centre) else $error("clock edge off centre");

  property p_tick_spacing;
    sub_tick |=> !sub_tick [*3];
  endproperty
  a_tick_spacing: assert property (p_tick_spacing) else $error("sub tick too close");

  // line a is judged on the select that was live when the flag was formed
  property p_flag_line;
    n.fifo_flag && !fifo_irq_on_b |=> interrupt_line_a;
  endproperty
  a_flag_line: assert property (p_flag_line) else $error("fifo flag missing on line a");

  property p_flag_def;
    1'b1 |=> (fifo_level_flag ==
      $past(fifo_enable & ~cont & (fifo_fill_count >= fifo_fill_limit)));
  endproperty
  a_flag_def: assert property (p_flag_def) else $error("fifo level flag wrong");

  property p_line_b_oe;
    cont |=> (interrupt_line_b_oe == !$past(bit_sync_bypass));
  endproperty
  a_line_b_oe: assert property (p_line_b_oe) else $error("line b drive wrong");

  property p_line_b_clock;
    cont |=> (interrupt_line_b_out == s.recovered_bit_clock);
  endproperty
  a_line_b_clock: assert property (p_line_b_clock) else $error("no bit clock on line b");

  property p_bypass_raw;
    cont && bypass_eff |=> (data_pin == $past(demod));
  endproperty
  a_bypass_raw: assert property (p_bypass_raw) else $error("raw data not on pin");

  property p_sync_data;
    cont && !bypass_eff |=> (data_pin == $past(s.bit_val));
  endproperty
  a_sync_data: assert property (p_sync_data) else $error("recovered bit not on pin");

  // the average only moves on a sample strobe
  property p_rssi_hold;
    !rssi_sample_valid |=> $stable(rssi_value);
  endproperty
  a_rssi_hold: assert property (p_rssi_hold) else $error("rssi moved without sample");

  property p_lock_stays;
    bit_sync_locked |=> bit_sync_locked;
  endproperty
  a_lock_stays: assert property (p_lock_stays) else $error("lock lost on equal run");

  property p_wr_pulse;
    fifo_wr_valid |=> !fifo_wr_valid;
  endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("fifo write longer than one cycle");

  property p_floor_clamp;
    dec_tick && !s.ook_q && (s.rssi <= s.peak) && (dec_val < floor_peak) && !floor_peak[8]
      |=> (s.peak == $past(floor_peak[7:0]));
  endproperty
  a_floor_clamp: assert property (p_floor_clamp) else $error("peak not held at floor");

endmodule

// ===== verif/otdb_tx_model.sv
// remote transmitter model: preamble, one payload byte, carrier level
`timescale 1ns/1ps
module otdb_tx_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // bench control
  input  wire logic       start,
  input  wire logic [7:0] payload,
  input  wire logic       carrier,
  input  wire logic [7:0] carrier_level,
  input  wire logic [6:0] bit_rate_value,
  // radio side
  output logic            fsk_raw_data,
  output logic [7:0]      rssi_sample,
  output logic            rssi_sample_valid,
  output logic            frame_start
);
  // ideal demod levels stand for a host that set deviation and index right
  int cyc;
  int bitn;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cyc <= 0;
      bitn <= 40;
      fsk_raw_data <= 1'b0;
      frame_start <= 1'b0;
      rssi_sample <= 8'h00;
      rssi_sample_valid <= 1'b0;
    end else begin
      rssi_sample_valid <= (cyc % 4) == 3;
      rssi_sample <= carrier ? carrier_level : 8'h00;
      frame_start <= 1'b0;
      cyc <= cyc + 1;
      if (start) begin
        cyc <= 0;
        bitn <= 0;
        fsk_raw_data <= 1'b0;
      end else if (cyc == 64 * (int'(bit_rate_value) + 1) - 1) begin
        cyc <= 0;
        bitn <= (bitn < 40) ? bitn + 1 : 40;
        // idle line is never left at its last level: it keeps toggling
        if (bitn < 31 || bitn >= 39) begin
          fsk_raw_data <= ~fsk_raw_data;
        end else begin
          fsk_raw_data <= payload[38 - bitn];
        end
        frame_start <= (bitn == 31);
      end
    end
  end
endmodule

// ===== verif/otdb_core_tb.sv
// self-checking bench for the ook demodulator and receive path
`timescale 1ns/1ps
module otdb_core_tb;
  import otdb_pkg::*;
  logic clk, sys_rst, rssi_sample_valid, fsk_raw_data, ook_select, bit_sync_bypass;
  logic [7:0] rssi_sample, floor_threshold_value, fixed_threshold_value, payload, carrier_level;
  logic [1:0] data_mode, ook_threshold_type, average_cutoff_select;
  logic [2:0] peak_decrement_step, peak_decrement_period;
  logic [6:0] bit_rate_value, fifo_fill_count, fifo_fill_limit;
  logic rx_enable, sync_match, fifo_enable, fifo_irq_on_b, fifo_wr_valid, data_pin;
  logic interrupt_line_a, interrupt_line_b_in, interrupt_line_b_out, interrupt_line_b_oe;
  logic [7:0] fifo_wr_data, rssi_value, tracked_peak;
  logic bit_sync_locked, fifo_level_flag, start, carrier, use_sync, host_b, frame_start;
  int fail_count, total_checks;
  logic [20:0] rows [5];

  // host side of line b only pulls when the device is not driving
  assign interrupt_line_b_in = interrupt_line_b_oe ? interrupt_line_b_out : host_b;
  assign sync_match = frame_start & use_sync;

  otdb_core i_otdb_core (.clk, .sys_rst, .rssi_sample, .rssi_sample_valid, .fsk_raw_data,
    .ook_select, .data_mode, .ook_threshold_type, .peak_decrement_step, .peak_decrement_period,
    .floor_threshold_value, .fixed_threshold_value, .average_cutoff_select, .bit_rate_value,
    .bit_sync_bypass, .rx_enable, .sync_match, .fifo_enable, .fifo_irq_on_b, .fifo_fill_count,
    .fifo_fill_limit, .fifo_wr_valid, .fifo_wr_data, .data_pin, .interrupt_line_a,
    .interrupt_line_b_in, .interrupt_line_b_out, .interrupt_line_b_oe, .rssi_value,
    .tracked_peak, .bit_sync_locked, .fifo_level_flag);

  otdb_tx_model i_otdb_tx_model (.clk, .sys_rst, .start, .payload, .carrier, .carrier_level,
    .bit_rate_value, .fsk_raw_data, .rssi_sample, .rssi_sample_valid, .frame_start);

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic step();
    @(posedge clk);
    #1;
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic chk1(string nm, logic e, logic g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s exp %b got %b", nm, e, g);
    end
  endtask

  task automatic wait_chg(output int n);
    logic [7:0] p;
    p = tracked_peak;
    n = 0;
    while (tracked_peak === p) begin
      step();
      n++;
      if (n > 2000) begin
        chk1("peak_change", 1'b1, 1'b0);
        complete_run();
      end
    end
  endtask

  task automatic frame(logic [1:0] md, logic sy, logic [7:0] exp_w);
    int n;
    logic [7:0] w;
    logic [7:0] d;
    data_mode = md;
    use_sync = sy;
    w = 8'h00;
    d = 8'h00;
    start = 1'b1;
    step();
    start = 1'b0;
    // window ends before a second byte of idle bits could complete
    for (n = 0; n < 2800; n++) begin
      step();
      if (fifo_wr_valid === 1'b1) begin
        w++;
        d = fifo_wr_data;
      end
    end
    chk("wr_count", exp_w, w);
    if (exp_w == 8'h01) chk("wr_data", payload, d);
    rx_enable = 1'b0;
    step();
    rx_enable = 1'b1;
    $display("test frame mode %b done", md);
  endtask

  task automatic decay(logic [2:0] s, logic [2:0] p, logic [7:0] d, int c);
    int n;
    logic [7:0] v;
    peak_decrement_step = s;
    peak_decrement_period = p;
    carrier = 1'b1;
    repeat (200) step();
    carrier = 1'b0;
    wait_chg(n);
    wait_chg(n);
    v = tracked_peak;
    wait_chg(n);
    chk("decay_step", d, v - tracked_peak);
    chk("decay_gap", c[7:0], n[7:0]);
    $display("test decay %0d %0d done", s, p);
  endtask

  initial begin
    // {mode, enable, on_b, count, limit, line_a, line_b, flag}
    rows = '{{2'b01, 2'b10, 7'd10, 7'd10, 3'b101}, {2'b01, 2'b11, 7'd11, 7'd10, 3'b011},
             {2'b01, 2'b10, 7'd9, 7'd10, 3'b000}, {2'b01, 2'b00, 7'd10, 7'd10, 3'b000},
             {2'b00, 2'b10, 7'd10, 7'd10, 3'b000}};
    {sys_rst, start, carrier, use_sync, host_b, ook_select} = 6'b100000;
    {bit_sync_bypass, rx_enable, fifo_enable, fifo_irq_on_b} = 4'b1100;
    data_mode = 2'b01;
    ook_threshold_type = 2'b00;
    average_cutoff_select = 2'b00;
    {peak_decrement_step, peak_decrement_period} = 6'h00;
    {floor_threshold_value, fixed_threshold_value} = 16'h1080;
    bit_rate_value = 7'h00;
    {fifo_fill_count, fifo_fill_limit} = 14'h0000;
    {payload, carrier_level} = 16'hb4f0;
    fail_count = 0;
    total_checks = 0;
    repeat (5) step();
    chk("peak_rst", 8'h00, tracked_peak);
    chk("rssi_rst", 8'h00, rssi_value);
    chk1("wr_rst", 1'b0, fifo_wr_valid);
    sys_rst = 1'b0;
    $display("test reset done");
    foreach (rows[i]) begin
      {data_mode, fifo_enable, fifo_irq_on_b, fifo_fill_count, fifo_fill_limit} = rows[i][20:3];
      repeat (3) step();
      chk1("line_a", rows[i][2], interrupt_line_a);
      chk1("line_b", rows[i][1], interrupt_line_b_out & interrupt_line_b_oe);
      chk1("level_flag", rows[i][0], fifo_level_flag);
    end
    fifo_enable = 1'b0;
    $display("test flag rows done");
    frame(2'b01, 1'b1, 8'h01);
    chk1("locked", 1'b1, bit_sync_locked);
    frame(2'b01, 1'b0, 8'h00);
    frame(2'b10, 1'b1, 8'h01);
    frame(2'b00, 1'b1, 8'h00);
    // continuous, ook path, fixed threshold, carrier on at 0x90
    {data_mode, ook_select, ook_threshold_type, carrier, carrier_level} = 14'h0b90;
    repeat (200) step();
    chk1("data_pin_hi", 1'b1, data_pin);
    chk1("b_oe_bypass", 1'b0, interrupt_line_b_oe);
    carrier_level = 8'h70;
    repeat (200) step();
    chk1("data_pin_lo", 1'b0, data_pin);
    bit_sync_bypass = 1'b0;
    repeat (10) step();
    chk1("b_oe_clock", 1'b1, interrupt_line_b_oe);
    $display("test continuous done");
    // buffered, peak threshold, carrier on at 0xf0
    {data_mode, ook_threshold_type, carrier, carrier_level} = 13'h09f0;
    repeat (200) step();
    chk("rssi", 8'hf0, rssi_value);
    chk("peak_rise", 8'hf0, tracked_peak);
    decay(3'h7, 3'h4, 8'h0c, 32);
    decay(3'h2, 3'h6, 8'h03, 8);
    for (int n = 0; n < 3000 && tracked_peak !== 8'h1c; n++) step();
    repeat (100) step();
    chk("peak_floor", 8'h1c, tracked_peak);
    $display("test floor done");
    complete_run();
  end
endmodule
